// ==== rtl/t8c_pkg.sv ====
package t8c_pkg;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
  localparam logic [7:0] ADDR_IRQEN   = 8'h10;

  localparam int CTRL_CS_LSB  = 0;
  localparam int CTRL_WGM_LSB = 3;
  localparam int CTRL_COM_LSB = 5;
  localparam int CTRL_FOC_BIT = 7;
  localparam int CTRL_AS_BIT  = 8;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;

  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXTF   = 3'h6;
  localparam logic [2:0] CS_EXTR   = 3'h7;

  localparam logic [9:0] PRE_TAP8   = 10'h007;
  localparam logic [9:0] PRE_TAP64  = 10'h03f;
  localparam logic [9:0] PRE_TAP256 = 10'h0ff;
  localparam logic [9:0] PRE_TAP1K  = 10'h3ff;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  typedef enum logic [1:0] {
    WGM_NORMAL,
    WGM_PHASE,
    WGM_CTC,
    WGM_FAST
  } t8c_wgm_e;

  typedef struct packed {
    logic [2:0] cs;
    t8c_wgm_e   wgm;
    logic [1:0] com;
    logic       async_sel;
  } t8c_ctrl_s;

  typedef struct packed {
    logic port_data;
    logic output_pin_direction;
  } t8c_pin_in_s;

  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } t8c_pin_out_s;

  typedef struct packed {
    t8c_ctrl_s   ctrl;
    logic [7:0]  cnt;
    logic [7:0]  ocr;
    logic [7:0]  ocr_buf;
    logic        dir_down;
    logic        oc;
    logic        ovf_flag;
    logic        cmp_flag;
    logic        ovf_ie;
    logic        cmp_ie;
    logic        block;
    logic [9:0]  pre;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_d;
    logic        xtal_s1;
    logic        xtal_s2;
    logic        xtal_d;
    logic [31:0] rdata;
  } t8c_state_s;

  localparam t8c_ctrl_s  CTRL_RESET  = '{cs: CS_STOP, wgm: WGM_NORMAL, com: COM_OFF,
                                         async_sel: 1'b0};
  localparam t8c_state_s STATE_RESET = '{ctrl: CTRL_RESET, pre: 10'h000,
                                         rdata: 32'h0000_0000, default: '0};

endpackage

// ==== rtl/t8c_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module t8c_timer (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // clock sources
  input  wire logic                  ext_clk_in,
  input  wire logic                  crystal_in_pin,
  // interrupt requests and acknowledges
  output logic                       irq_compare,
  output logic                       irq_overflow,
  input  wire logic                  ack_compare,
  input  wire logic                  ack_overflow,
  // port pin
  input  wire t8c_pkg::t8c_pin_in_s  pin_in,
  output t8c_pkg::t8c_pin_out_s      pin_ctl,
  output logic                       waveform_output,
  // counter indications
  output logic                       count_top,
  output logic                       count_bottom
);

  t8c_pkg::t8c_state_s r_reg;
  t8c_pkg::t8c_state_s r_next;

  logic       acc;
  logic       wr;
  logic       hit;
  logic       ctrl_wr;
  logic       cnt_wr;
  logic       cmp_wr;
  logic       flag_wr;
  logic       ie_wr;
  logic       pwm;
  logic       base;
  logic       tick;
  logic       match;
  logic [7:0] top_val;

  // bus decode
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign hit     = (paddr == t8c_pkg::ADDR_CTRL) | (paddr == t8c_pkg::ADDR_COUNT)
                 | (paddr == t8c_pkg::ADDR_COMPARE) | (paddr == t8c_pkg::ADDR_FLAGS)
                 | (paddr == t8c_pkg::ADDR_IRQEN);
  assign ctrl_wr = wr & (paddr == t8c_pkg::ADDR_CTRL);
  assign cnt_wr  = wr & (paddr == t8c_pkg::ADDR_COUNT);
  assign cmp_wr  = wr & (paddr == t8c_pkg::ADDR_COMPARE);
  assign flag_wr = wr & (paddr == t8c_pkg::ADDR_FLAGS);
  assign ie_wr   = wr & (paddr == t8c_pkg::ADDR_IRQEN);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = r_reg.rdata;

  assign pwm = (r_reg.ctrl.wgm == t8c_pkg::WGM_PHASE) | (r_reg.ctrl.wgm == t8c_pkg::WGM_FAST);

  // timer clock selection
  always_comb begin
    base = r_reg.ctrl.async_sel ? (r_reg.xtal_s2 & ~r_reg.xtal_d) : 1'b1;
    case (r_reg.ctrl.cs)
      t8c_pkg::CS_STOP:   tick = 1'b0;
      t8c_pkg::CS_DIV1:   tick = base;
      t8c_pkg::CS_DIV8:   tick = base & ((r_reg.pre & t8c_pkg::PRE_TAP8) == t8c_pkg::PRE_TAP8);
      t8c_pkg::CS_DIV64:  tick = base & ((r_reg.pre & t8c_pkg::PRE_TAP64) == t8c_pkg::PRE_TAP64);
      t8c_pkg::CS_DIV256: tick = base
                               & ((r_reg.pre & t8c_pkg::PRE_TAP256) == t8c_pkg::PRE_TAP256);
      t8c_pkg::CS_DIV1K:  tick = base & (r_reg.pre == t8c_pkg::PRE_TAP1K);
      t8c_pkg::CS_EXTF:   tick = ~r_reg.ext_s2 & r_reg.ext_d;
      t8c_pkg::CS_EXTR:   tick = r_reg.ext_s2 & ~r_reg.ext_d;
      default:            tick = 1'b0;
    endcase
  end

  // comparator, blocked right after a count write
  assign match   = (r_reg.cnt == r_reg.ocr) & ~r_reg.block;
  assign top_val = (r_reg.ctrl.wgm == t8c_pkg::WGM_CTC) ? r_reg.ocr : t8c_pkg::CNT_MAX;

  function automatic logic com_act(input logic [1:0] com, input logic oc);
    case (com)
      t8c_pkg::COM_TOGGLE: com_act = ~oc;
      t8c_pkg::COM_CLEAR:  com_act = 1'b0;
      t8c_pkg::COM_SET:    com_act = 1'b1;
      default:             com_act = oc;
    endcase
  endfunction

  always_comb begin
    logic set_ovf;
    logic set_cmp;
    logic nonpwm_new;
    r_next     = r_reg;
    set_ovf    = 1'b0;
    set_cmp    = 1'b0;
    nonpwm_new = 1'b0;
    // synchronisers
    r_next.ext_s1  = ext_clk_in;
    r_next.ext_s2  = r_reg.ext_s1;
    r_next.ext_d   = r_reg.ext_s2;
    r_next.xtal_s1 = crystal_in_pin;
    r_next.xtal_s2 = r_reg.xtal_s1;
    r_next.xtal_d  = r_reg.xtal_s2;
    if (base && r_reg.ctrl.cs != t8c_pkg::CS_STOP) begin
      r_next.pre = r_reg.pre + 10'h001;
    end
    // counting
    if (tick) begin
      r_next.block = 1'b0;
      set_cmp      = match;
      case (r_reg.ctrl.wgm)
        t8c_pkg::WGM_NORMAL: begin
          r_next.cnt      = r_reg.cnt + t8c_pkg::CNT_ONE;
          r_next.dir_down = 1'b0;
          set_ovf         = (r_reg.cnt == t8c_pkg::CNT_MAX);
          if (match) begin
            r_next.oc = com_act(r_reg.ctrl.com, r_reg.oc);
          end
        end
        t8c_pkg::WGM_CTC: begin
          r_next.dir_down = 1'b0;
          if (r_reg.cnt == r_reg.ocr) begin
            r_next.cnt = t8c_pkg::CNT_BOTTOM;
          end else begin
            r_next.cnt = r_reg.cnt + t8c_pkg::CNT_ONE;
          end
          set_ovf = (r_reg.cnt == t8c_pkg::CNT_MAX);
          if (match) begin
            r_next.oc = com_act(r_reg.ctrl.com, r_reg.oc);
          end
        end
        t8c_pkg::WGM_FAST: begin
          r_next.cnt      = r_reg.cnt + t8c_pkg::CNT_ONE;
          r_next.dir_down = 1'b0;
          set_ovf         = (r_reg.cnt == t8c_pkg::CNT_MAX - t8c_pkg::CNT_ONE);
          if (match) begin
            r_next.oc = com_act(r_reg.ctrl.com, r_reg.oc);
          end
          if (r_reg.cnt == t8c_pkg::CNT_MAX) begin
            r_next.ocr = r_reg.ocr_buf;
            if (r_reg.ctrl.com == t8c_pkg::COM_CLEAR) begin
              r_next.oc = 1'b1;
            end else if (r_reg.ctrl.com == t8c_pkg::COM_SET) begin
              r_next.oc = 1'b0;
            end
          end
        end
        t8c_pkg::WGM_PHASE: begin
          if (r_reg.dir_down) begin
            r_next.cnt = r_reg.cnt - t8c_pkg::CNT_ONE;
          end else begin
            r_next.cnt = r_reg.cnt + t8c_pkg::CNT_ONE;
          end
          if (r_next.cnt == t8c_pkg::CNT_MAX) begin
            r_next.dir_down = 1'b1;
          end else if (r_next.cnt == t8c_pkg::CNT_BOTTOM) begin
            r_next.dir_down = 1'b0;
          end
          set_ovf = (r_next.cnt == t8c_pkg::CNT_BOTTOM);
          if (r_reg.cnt == t8c_pkg::CNT_MAX) begin
            r_next.ocr = r_reg.ocr_buf;
          end
          if (match && r_reg.ctrl.com[1]) begin
            r_next.oc = r_reg.dir_down ^ r_reg.ctrl.com[0];
          end
        end
        default: begin
          r_next.cnt = r_reg.cnt;
        end
      endcase
    end
    // register writes, after counting so they win
    if (ctrl_wr) begin
      r_next.ctrl.cs        = pwdata[t8c_pkg::CTRL_CS_LSB +: 3];
      r_next.ctrl.wgm       = t8c_pkg::t8c_wgm_e'(pwdata[t8c_pkg::CTRL_WGM_LSB +: 2]);
      r_next.ctrl.com       = pwdata[t8c_pkg::CTRL_COM_LSB +: 2];
      r_next.ctrl.async_sel = pwdata[t8c_pkg::CTRL_AS_BIT];
      nonpwm_new = (r_next.ctrl.wgm == t8c_pkg::WGM_NORMAL)
                 | (r_next.ctrl.wgm == t8c_pkg::WGM_CTC);
      if (pwdata[t8c_pkg::CTRL_FOC_BIT] && nonpwm_new) begin
        r_next.oc = com_act(r_next.ctrl.com, r_next.oc);
      end
    end
    if (cnt_wr) begin
      r_next.cnt   = pwdata[7:0];
      r_next.block = 1'b1;
    end
    if (cmp_wr) begin
      if (pwm) begin
        r_next.ocr_buf = pwdata[7:0];
      end else begin
        r_next.ocr     = pwdata[7:0];
        r_next.ocr_buf = pwdata[7:0];
      end
    end
    if (ie_wr) begin
      r_next.ovf_ie = pwdata[t8c_pkg::FLAG_OVF_BIT];
      r_next.cmp_ie = pwdata[t8c_pkg::FLAG_CMP_BIT];
    end
    // flags: set wins over clear
    r_next.ovf_flag = set_ovf | (r_reg.ovf_flag & ~ack_overflow
                    & ~(flag_wr & pwdata[t8c_pkg::FLAG_OVF_BIT]));
    r_next.cmp_flag = set_cmp | (r_reg.cmp_flag & ~ack_compare
                    & ~(flag_wr & pwdata[t8c_pkg::FLAG_CMP_BIT]));
    // read data captured in the setup phase
    if (psel && !penable) begin
      r_next.rdata = 32'h0000_0000;
      case (paddr)
        t8c_pkg::ADDR_CTRL: begin
          r_next.rdata[t8c_pkg::CTRL_CS_LSB +: 3]  = r_reg.ctrl.cs;
          r_next.rdata[t8c_pkg::CTRL_WGM_LSB +: 2] = r_reg.ctrl.wgm;
          r_next.rdata[t8c_pkg::CTRL_COM_LSB +: 2] = r_reg.ctrl.com;
          r_next.rdata[t8c_pkg::CTRL_AS_BIT]       = r_reg.ctrl.async_sel;
        end
        t8c_pkg::ADDR_COUNT:   r_next.rdata[7:0] = r_reg.cnt;
        t8c_pkg::ADDR_COMPARE: r_next.rdata[7:0] = pwm ? r_reg.ocr_buf : r_reg.ocr;
        t8c_pkg::ADDR_FLAGS: begin
          r_next.rdata[t8c_pkg::FLAG_OVF_BIT] = r_reg.ovf_flag;
          r_next.rdata[t8c_pkg::FLAG_CMP_BIT] = r_reg.cmp_flag;
        end
        t8c_pkg::ADDR_IRQEN: begin
          r_next.rdata[t8c_pkg::FLAG_OVF_BIT] = r_reg.ovf_ie;
          r_next.rdata[t8c_pkg::FLAG_CMP_BIT] = r_reg.cmp_ie;
        end
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= t8c_pkg::STATE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs
  assign irq_compare      = r_reg.cmp_flag & r_reg.cmp_ie;
  assign irq_overflow     = r_reg.ovf_flag & r_reg.ovf_ie;
  assign waveform_output  = r_reg.oc;
  assign pin_ctl.pin_out  = (r_reg.ctrl.com != t8c_pkg::COM_OFF) ? r_reg.oc
                                                                 : pin_in.port_data;
  assign pin_ctl.pin_oe_n = ~pin_in.output_pin_direction;
  assign count_top        = (r_reg.cnt == top_val);
  assign count_bottom     = (r_reg.cnt == t8c_pkg::CNT_BOTTOM);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_write_wins: assert property (cnt_wr |=> r_reg.cnt == $past(pwdata[7:0]))
    else $error("count write lost");
  a_stop_holds_count: assert property ((r_reg.ctrl.cs == t8c_pkg::CS_STOP) && !cnt_wr
                                       |=> $stable(r_reg.cnt))
    else $error("stopped counter moved");
  a_match_sets_flag: assert property (tick && match |=> r_reg.cmp_flag)
    else $error("match flag not set");
  a_block_after_write: assert property (tick && r_reg.block && !r_reg.cmp_flag
                                        |=> !r_reg.cmp_flag)
    else $error("blocked match set flag");
  a_com_zero_hold: assert property ((r_reg.ctrl.com == t8c_pkg::COM_OFF) && !ctrl_wr
                                    |=> $stable(r_reg.oc))
    else $error("output changed with mode off");
  a_pin_override: assert property ((r_reg.ctrl.com != t8c_pkg::COM_OFF)
                                   |-> pin_ctl.pin_out == r_reg.oc)
    else $error("pin not overridden");
  a_normal_overflow: assert property (tick && (r_reg.ctrl.wgm == t8c_pkg::WGM_NORMAL)
                                      && (r_reg.cnt == t8c_pkg::CNT_MAX) && !cnt_wr
                                      |=> r_reg.ovf_flag && r_reg.cnt == t8c_pkg::CNT_BOTTOM)
    else $error("normal wrap without overflow");
  a_phase_turn: assert property (tick && (r_reg.ctrl.wgm == t8c_pkg::WGM_PHASE)
                                 && !ctrl_wr && (r_reg.cnt == t8c_pkg::CNT_MAX) && !cnt_wr
                                 |=> r_reg.cnt == 8'hfe)
    else $error("phase counter did not turn");
  a_phase_match_out: assert property (tick && match && !ctrl_wr
                                      && (r_reg.ctrl.wgm == t8c_pkg::WGM_PHASE)
                                      && (r_reg.ctrl.com == t8c_pkg::COM_CLEAR)
                                      |=> r_reg.oc == $past(r_reg.dir_down))
    else $error("phase output action wrong");
  a_flag_ack_clear: assert property (ack_compare && !(tick && match) |=> !r_reg.cmp_flag)
    else $error("ack did not clear flag");

endmodule
`default_nettype wire

// ==== sim/t8c_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module t8c_pin_model (
  // pin control from the timer
  input  wire t8c_pkg::t8c_pin_out_s pin_ctl,
  // pad level and crystal clock
  output logic                       pad,
  output logic                       crystal
);
  // pull-up holds a released pad high
  assign pad = pin_ctl.pin_oe_n ? 1'b1 : pin_ctl.pin_out;
  // free running watch crystal, unrelated to pclk
  initial begin
    crystal = 1'b0;
    forever #31 crystal = ~crystal;
  end
endmodule
`default_nettype wire

// ==== sim/t8c_timer_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module t8c_timer_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } t8c_row_s;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  ack;
  logic                  ext_clk;
  logic                  irq_cmp;
  logic                  irq_ovf;
  logic                  crystal;
  logic                  pad;
  logic                  wo;
  logic                  top;
  logic                  bottom;
  t8c_pkg::t8c_pin_in_s  pin_in;
  t8c_pkg::t8c_pin_out_s pin_ctl;
  t8c_row_s              rows [8];
  logic [31:0]           rd;
  logic [31:0]           keep;
  logic                  err;
  int                    n_errors;
  int                    checks;
  int                    n;

  t8c_timer i_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .ext_clk_in     (ext_clk),
    .crystal_in_pin (crystal),
    .irq_compare    (irq_cmp),
    .irq_overflow   (irq_ovf),
    .ack_compare    (ack),
    .ack_overflow   (1'b0),
    .pin_in         (pin_in),
    .pin_ctl        (pin_ctl),
    .waveform_output(wo),
    .count_top      (top),
    .count_bottom   (bottom)
  );
  t8c_pin_model i_pin (.pin_ctl(pin_ctl), .pad(pad), .crystal(crystal));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] wgm,
                                      input logic [1:0] com, input logic foc, input logic as);
    return {23'h0, as, foc, com, wgm, cs};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k == 16) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_on(input logic want_top, output int cnt);
    cnt = 0;
    while ((want_top ? top : bottom) !== 1'b1 && cnt < 1000) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
    if (cnt == 1000) n_errors++;
  endtask

  task automatic duty(output int hi);
    hi = 0;
    repeat (256) begin
      @(posedge pclk);
      #1;
      if (wo === 1'b1) hi++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack = 1'b0;
    ext_clk = 1'b0;
    pin_in = '0;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rows[0] = '{t8c_pkg::ADDR_COUNT, 32'h0000_00a5, 32'h0000_00a5};
    rows[1] = '{t8c_pkg::ADDR_COMPARE, 32'h0000_003c, 32'h0000_003c};
    rows[2] = '{t8c_pkg::ADDR_IRQEN, 32'h0000_0003, 32'h0000_0003};
    rows[3] = '{t8c_pkg::ADDR_CTRL, ctl(3'h0, 2'h3, 2'h3, 1'b1, 1'b0), ctl(3'h0, 2'h3, 2'h3, 1'b0, 1'b0)};
    rows[4] = '{t8c_pkg::ADDR_COMPARE, 32'h0000_0077, 32'h0000_0077};
    rows[5] = '{8'h14, 32'h0000_0055, 32'h0};
    rows[6] = '{t8c_pkg::ADDR_CTRL, 32'h0, 32'h0};
    rows[7] = '{t8c_pkg::ADDR_IRQEN, 32'h0, 32'h0};
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk(32'(err), 32'(rows[i].a == 8'h14));
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    $display("test register table done");
    chk(32'(wo), 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'((i + 1) % 4 * 3 % 4), 1'b1, 1'b0));
      @(posedge pclk);
      #1;
      chk(32'(wo), 32'(i != 1));
      chk(32'(pin_ctl.pin_out), 32'(i != 1 && i != 3));
    end
    rdc(t8c_pkg::ADDR_FLAGS, 32'h0);
    rdc(t8c_pkg::ADDR_COUNT, 32'h0000_00a5);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h0, 2'h2, 2'h2, 1'b0, 1'b0));
    pin_in.output_pin_direction <= 1'b1;
    #1;
    chk(32'(wo), 32'h1);
    chk(32'({pad, pin_ctl.pin_oe_n}), 32'h2);
    $display("test force and pin done");
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'h0, 1'b0, 1'b0));
    apb(1'b1, t8c_pkg::ADDR_COMPARE, 32'h10);
    apb(1'b1, t8c_pkg::ADDR_COUNT, 32'h10);
    apb(1'b1, t8c_pkg::ADDR_IRQEN, 32'h3);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0, 1'b0));
    rdc(t8c_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, t8c_pkg::ADDR_COUNT, 32'h80);
    apb(1'b0, t8c_pkg::ADDR_COUNT, 32'h0);
    chk_rng(rd, 8'h80, 8'h84);
    wait_on(1'b1, n);
    chk(32'(irq_ovf), 32'h0);
    @(posedge pclk);
    #1;
    chk(32'({bottom, irq_ovf}), 32'h3);
    repeat (20) @(posedge pclk);
    #1;
    chk(32'(irq_cmp), 32'h1);
    apb(1'b1, t8c_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, t8c_pkg::ADDR_FLAGS, 32'h1);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    @(posedge pclk);
    #1;
    chk(32'({irq_cmp, irq_ovf}), 32'h0);
    $display("test match and overflow done");
    apb(1'b1, t8c_pkg::ADDR_COMPARE, 32'h20);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h1, 2'h1, 2'h2, 1'b0, 1'b0));
    wait_on(1'b1, n);
    chk(32'(wo), 32'h0);
    wait_on(1'b0, n);
    chk(32'(n), 32'd255);
    chk(32'(wo), 32'h1);
    apb(1'b1, t8c_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, t8c_pkg::ADDR_COUNT, 32'h0);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0, 1'b1));
    repeat (80) @(posedge pclk);
    apb(1'b1, t8c_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, t8c_pkg::ADDR_COUNT, 32'h0);
    chk_rng(rd, 8, 13);
    keep = rd;
    repeat (20) @(posedge pclk);
    rdc(t8c_pkg::ADDR_COUNT, keep);
    $display("test phase and async done");
    apb(1'b1, t8c_pkg::ADDR_COUNT, 32'h0);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h2, 2'h0, 2'h0, 1'b0, 1'b0));
    repeat (64) @(posedge pclk);
    apb(1'b1, t8c_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, t8c_pkg::ADDR_COUNT, 32'h0);
    chk_rng(rd, 8, 9);
    apb(1'b1, t8c_pkg::ADDR_COUNT, 32'h0);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h7, 2'h0, 2'h0, 1'b0, 1'b0));
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    apb(1'b1, t8c_pkg::ADDR_CTRL, 32'h0);
    rdc(t8c_pkg::ADDR_COUNT, 32'h0000_0005);
    $display("test prescaler and external clock done");
    apb(1'b1, t8c_pkg::ADDR_COMPARE, 32'h40);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h1, 2'h3, 2'h2, 1'b0, 1'b0));
    wait_on(1'b1, n);
    duty(n);
    chk_rng(32'(n), 8'h40, 8'h42);
    apb(1'b1, t8c_pkg::ADDR_CTRL, ctl(3'h1, 2'h3, 2'h3, 1'b0, 1'b0));
    wait_on(1'b1, n);
    duty(n);
    chk_rng(32'(n), 8'hbe, 8'hc0);
    $display("test fast pwm done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'({bottom, top, wo}), 32'h4);
    rdc(t8c_pkg::ADDR_CTRL, 32'h0);
    rdc(t8c_pkg::ADDR_FLAGS, 32'h0);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
